// *** src/three_channel_timer_counter_core.sv ***
// Three-channel 16-bit timer/counter core with an APB register slave.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tc_core_cfg.svh"

// Functional notes
// - Three identical independent channels, each with a 16-bit up-counter.
// - Five shared internal ticks: master clock divided by 2,8,32,128,1024.
// - Counter increments by one on each rising edge of selected clock.
// - Wrap from all ones to zero sets the overflow flag in status.
// - Live counter value readable at any time through counter value register.
// - Trigger zeroes counter on next valid selected clock edge, not at once.
// - Block mode register routes each external clock to pin, io A or a held-low level.
// - Clock select field picks one of five internal or three external clocks.
// - Clock invert bit makes the channel count on the opposite edge.
// - Gating field picks none or an external input; clock passes while high.
// - Clock enable and disable commands in channel control switch counting.
// - B load in capture or RC match in waveform may disable clock.
// - While disabled, start and stop do nothing; only enable re-enables.
// - Clock-enabled status bit shows whenever the channel clock is enabled.
// - Any trigger starts the counter clock.
// - B load in capture or RC match in waveform may stop clock.
// - Start and stop act only while the clock is enabled.
// - Mode bit picks capture or waveform mode per channel.
// - Capture: io lines input. Waveform: A drives, B unless trigger source.
// - Trigger resets counter and starts clock; three common, one external.
// - Each channel drives its own interrupt output.
// - Software trigger bit triggers a channel; block sync triggers all three.
// - RC compare trigger bit makes counter equal RC raise a trigger.
module three_channel_timer_counter_core
(
    input  wire logic                    clk,
    input  wire logic                    reset,
    input  wire tc_core_pkg::apb_addr_t  paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire tc_core_pkg::apb_data_t  pwdata,
    output var  tc_core_pkg::apb_data_t  prdata,
    output var  logic                    pready,
    output var  logic                    pslverr,
    input  wire tc_core_pkg::chan_vec_t  external_clock_pins,
    input  wire tc_core_pkg::chan_vec_t  io_line_a_in,
    output var  tc_core_pkg::chan_vec_t  io_line_a_out,
    output var  tc_core_pkg::chan_vec_t  io_line_a_oe,
    input  wire tc_core_pkg::chan_vec_t  io_line_b_in,
    output var  tc_core_pkg::chan_vec_t  io_line_b_out,
    output var  tc_core_pkg::chan_vec_t  io_line_b_oe,
    output var  tc_core_pkg::chan_vec_t  chan_irq
);
    import tc_core_pkg::*;

    // Level of the selected source: internal prescaler bit or external clock.
    function automatic logic sel_level(input logic [2:0] sel,
                                       input logic [9:0] pre,
                                       input chan_vec_t  xc);
        logic r;
        r = 1'b0;
        unique case (sel)
            3'h0: r = pre[0];
            3'h1: r = pre[2];
            3'h2: r = pre[4];
            3'h3: r = pre[6];
            3'h4: r = pre[9];
            3'h5: r = xc[0];
            3'h6: r = xc[1];
            3'h7: r = xc[2];
        endcase
        return r;
    endfunction

    // Edge detector: none, rising, falling or both.
    function automatic logic edge_hit(input edge_sel_t es,
                                      input logic cur,
                                      input logic prv);
        logic r;
        r = 1'b0;
        unique case (es)
            2'h0: r = 1'b0;
            2'h1: r = cur & ~prv;
            2'h2: r = ~cur & prv;
            2'h3: r = cur ^ prv;
        endcase
        return r;
    endfunction

    logic [9:0]              presc_ff;
    logic [`MODE_WIDTH-1:0]  mode_ff [3];
    count_t                  cv_ff [3];
    count_t                  capb_ff [3];
    count_t                  cmpc_ff [3];
    logic [`ST_STICKY_W-1:0] sticky_ff [3];
    logic [`ST_STICKY_W-1:0] imask_ff [3];
    logic [5:0]              bmode_ff;
    chan_vec_t               en_ff;
    chan_vec_t               run_ff;
    chan_vec_t               pend_ff;
    chan_vec_t               clk_lvl_ff;
    chan_vec_t               trg_lvl_ff;
    chan_vec_t               ioa_prev_ff;
    logic [31:0]             rd_mask_ff;

    chan_vec_t               xc;
    chan_vec_t               lvl;
    chan_vec_t               trg_sig;
    chan_vec_t               active;
    chan_vec_t               ovf_evt;
    chan_vec_t               cmp_evt;
    chan_vec_t               ldb_evt;
    chan_vec_t               ext_trig;
    chan_vec_t               trig;
    chan_vec_t               start_evt;
    chan_vec_t               stop_evt;
    chan_vec_t               dis_evt;
    chan_vec_t               cmd_en;
    chan_vec_t               cmd_dis;
    chan_vec_t               sel_ch;
    count_t                  nxt_cv [3];
    logic                    bus_wr;
    logic                    bus_done;
    logic                    sync_wr;
    logic [5:0]              ch_off;
    logic [1:0]              ch_idx;
    logic                    ch_hit;
    apb_data_t               nxt_rdata;
    logic                    nxt_err;

    assign bus_done = psel & penable & pready;
    assign bus_wr   = bus_done & pwrite;
    assign ch_idx   = paddr[7:6];
    assign ch_off   = paddr[5:0];
    assign ch_hit   = (ch_idx != 2'h3);
    assign sync_wr  = bus_wr & (paddr == `OFF_BLK_CTRL)
                      & pwdata[`BCTRL_SYNC];

    // Chaining: 0 pin, 1 held low, 2 and 3 io A of the other two channels.
    always_comb
    begin
        for (int j = 0; j < 3; j++)
        begin
            unique case (bmode_ff[2*j +: 2])
                2'h0: xc[j] = external_clock_pins[j];
                2'h1: xc[j] = 1'b0;
                2'h2: xc[j] = io_line_a_in[(j + 1) % 3];
                2'h3: xc[j] = io_line_a_in[(j + 2) % 3];
            endcase
        end
    end

    // External clocks are edge-detected on the master clock, so they must
    // stay below the sampling limit; faster sources silently lose counts.
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            logic [1:0] burst;
            logic [1:0] eevt;
            logic       wave;
            burst = mode_ff[i][`MODE_BURST_LSB +: 2];
            eevt  = mode_ff[i][`MODE_EEVT_LSB +: 2];
            wave  = mode_ff[i][`MODE_WAVE];
            lvl[i] = (sel_level(mode_ff[i][`MODE_CLKSEL_LSB +: 3], presc_ff,
                      xc) ^ mode_ff[i][`MODE_CLOCK_INVERT_BIT])
                     & ((burst == 2'h0) | xc[burst - 2'h1]);
            active[i] = lvl[i] & ~clk_lvl_ff[i] & en_ff[i] & run_ff[i];
            nxt_cv[i] = pend_ff[i] ? `CV_ZERO : cv_ff[i] + 16'h0001;
            ovf_evt[i] = active[i] & ~pend_ff[i]
                         & (cv_ff[i] == `CV_MAX);
            cmp_evt[i] = active[i] & (nxt_cv[i] == cmpc_ff[i]);
            ldb_evt[i] = ~wave & io_line_a_in[i] & ~ioa_prev_ff[i];
            if (wave)
                trg_sig[i] = (eevt == 2'h0) ? io_line_b_in[i]
                                            : xc[eevt - 2'h1];
            else
                trg_sig[i] = mode_ff[i][`MODE_ABETRG] ? io_line_a_in[i]
                                                      : io_line_b_in[i];
            ext_trig[i] = edge_hit(wave ? mode_ff[i][`MODE_EEVTEDG_LSB +: 2]
                                        : mode_ff[i][`MODE_ETRGEDG_LSB +: 2],
                                   trg_sig[i], trg_lvl_ff[i])
                          & (~wave | mode_ff[i][`MODE_ENETRG]);
            sel_ch[i]  = bus_wr & ch_hit & (ch_idx == 2'(i))
                         & (ch_off == `OFF_CTRL);
            cmd_en[i]  = sel_ch[i] & pwdata[`CTRL_CLOCK_ENABLE_COMMAND];
            cmd_dis[i] = sel_ch[i] & pwdata[`CTRL_CLOCK_DISABLE_COMMAND];
            trig[i] = (sel_ch[i] & pwdata[`CTRL_SOFTWARE_TRIGGER_BIT]) | sync_wr
                      | ext_trig[i]
                      | (cmp_evt[i] & mode_ff[i][`MODE_RC_COMPARE_TRIGGER_ENABLE]);
            start_evt[i] = trig[i];
            stop_evt[i] = wave ? cmp_evt[i] & mode_ff[i][`MODE_STOP_ON_RC_COMPARE]
                               : ldb_evt[i] & mode_ff[i][`MODE_STOP_ON_B_LOAD];
            dis_evt[i] = wave ? cmp_evt[i] & mode_ff[i][`MODE_DISABLE_ON_RC_COMPARE]
                              : ldb_evt[i] & mode_ff[i][`MODE_DISABLE_ON_B_LOAD];
        end
    end

    // Free-running prescaler shared by every channel.
    always_ff @(posedge clk)
    begin
        if (reset)
            presc_ff <= 10'h000;
        else
            presc_ff <= presc_ff + 10'h001;
    end

    // Edge history of clock, trigger source and io A per channel.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            clk_lvl_ff  <= 3'h0;
            trg_lvl_ff  <= 3'h0;
            ioa_prev_ff <= 3'h0;
        end
        else
        begin
            clk_lvl_ff  <= lvl;
            trg_lvl_ff  <= trg_sig;
            ioa_prev_ff <= io_line_a_in;
        end
    end

    // Enable and start/stop control; disable wins over a same-cycle enable.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            en_ff  <= 3'h0;
            run_ff <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (cmd_dis[i] | dis_evt[i])
                    en_ff[i] <= 1'b0;
                else if (cmd_en[i])
                    en_ff[i] <= 1'b1;
                if (~(en_ff[i] | cmd_en[i]) | cmd_dis[i] | dis_evt[i])
                    run_ff[i] <= 1'b0;
                else if (start_evt[i])
                    run_ff[i] <= 1'b1;
                else if (stop_evt[i])
                    run_ff[i] <= 1'b0;
            end
        end
    end

    // Counter with deferred trigger reset; the pending flag survives until
    // a counting edge arrives or the clock is disabled, so a slow clock shows a stale value for a while.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pend_ff <= 3'h0;
            for (int i = 0; i < 3; i++)
                cv_ff[i] <= `CV_ZERO;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (active[i])
                    cv_ff[i] <= nxt_cv[i];
                if (trig[i] & (en_ff[i] | cmd_en[i]))
                    pend_ff[i] <= 1'b1;
                else if (active[i] | ~en_ff[i])
                    pend_ff[i] <= 1'b0;
            end
        end
    end

    // Capture register B loads on a rising io A edge in capture mode.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 3; i++)
                capb_ff[i] <= `CV_ZERO;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
                if (ldb_evt[i])
                    capb_ff[i] <= cv_ff[i];
        end
    end

    // Software-written configuration.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            bmode_ff <= `BMODE_RESET;
            for (int i = 0; i < 3; i++)
            begin
                mode_ff[i]  <= `MODE_RESET;
                cmpc_ff[i]  <= `CMPC_RESET;
                imask_ff[i] <= 8'h00;
            end
        end
        else if (bus_wr)
        begin
            if (paddr == `OFF_BLK_MODE)
                bmode_ff <= pwdata[5:0];
            for (int i = 0; i < 3; i++)
            begin
                if (ch_hit & (ch_idx == 2'(i)))
                begin
                    if (ch_off == `OFF_MODE)
                        mode_ff[i] <= pwdata[`MODE_WIDTH-1:0];
                    if (ch_off == `OFF_CMPC)
                        cmpc_ff[i] <= pwdata[15:0];
                    if (ch_off == `OFF_IMASK)
                        imask_ff[i] <= pwdata[`ST_STICKY_W-1:0];
                end
            end
        end
    end

    // Sticky status: clear-on-read only drops bits the read returned, and a
    // new event in the clearing cycle sets the bit again.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < 3; i++)
                sticky_ff[i] <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                logic [`ST_STICKY_W-1:0] clr;
                logic [`ST_STICKY_W-1:0] set;
                clr = 8'h00;
                set = 8'h00;
                if (bus_done & ~pwrite & ch_hit & (ch_idx == 2'(i))
                    & (ch_off == `OFF_STATUS))
                    clr = rd_mask_ff[`ST_STICKY_W-1:0];
                set[`ST_OVF]  = ovf_evt[i];
                set[`ST_CPC]  = cmp_evt[i];
                set[`ST_LDB]  = ldb_evt[i];
                set[`ST_ETRG] = ext_trig[i];
                sticky_ff[i] <= (sticky_ff[i] & ~clr) | set;
            end
        end
    end

    // Pin direction, waveform output on io A and per-channel interrupts.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            io_line_a_out <= 3'h0;
            io_line_a_oe  <= 3'h0;
            io_line_b_out <= 3'h0;
            io_line_b_oe  <= 3'h0;
            chan_irq      <= 3'h0;
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                io_line_a_oe[i] <= mode_ff[i][`MODE_WAVE];
                io_line_b_oe[i] <= mode_ff[i][`MODE_WAVE]
                    & (mode_ff[i][`MODE_EEVT_LSB +: 2] != 2'h0);
                if (~mode_ff[i][`MODE_WAVE])
                    io_line_a_out[i] <= 1'b0;
                else if (cmp_evt[i])
                    io_line_a_out[i] <= ~io_line_a_out[i];
                io_line_b_out[i] <= 1'b0;
                chan_irq[i] <= |(sticky_ff[i] & imask_ff[i]);
            end
        end
    end

    // Read mux for the bus.
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        nxt_err   = 1'b0;
        if (ch_hit)
        begin
            unique case (ch_off)
                `OFF_CTRL:   nxt_rdata = 32'h0000_0000;
                `OFF_MODE:   nxt_rdata = 32'(mode_ff[ch_idx]);
                `OFF_VALUE:  nxt_rdata = 32'(cv_ff[ch_idx]);
                `OFF_CAPB:   nxt_rdata = 32'(capb_ff[ch_idx]);
                `OFF_CMPC:   nxt_rdata = 32'(cmpc_ff[ch_idx]);
                `OFF_STATUS:
                begin
                    nxt_rdata = 32'(sticky_ff[ch_idx]);
                    nxt_rdata[`ST_CLOCK_ENABLED_STATUS] = en_ff[ch_idx];
                    nxt_rdata[`ST_IOA] = io_line_a_in[ch_idx];
                    nxt_rdata[`ST_IOB] = io_line_b_in[ch_idx];
                end
                `OFF_IMASK:  nxt_rdata = 32'(imask_ff[ch_idx]);
                default:     nxt_err = 1'b1;
            endcase
        end
        else if (paddr == `OFF_BLK_MODE)
            nxt_rdata = 32'(bmode_ff);
        else if (paddr != `OFF_BLK_CTRL)
            nxt_err = 1'b1;
    end

    // No wait state: the answer is prepared in setup, given in the first access cycle.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prdata     <= 32'h0000_0000;
            rd_mask_ff <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata     <= pwrite ? 32'h0000_0000 : nxt_rdata;
            rd_mask_ff <= nxt_rdata;
            pready     <= 1'b1;
            pslverr    <= nxt_err;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** src/tc_core_cfg.svh ***
// Register offsets, field positions and reset values of the timer core.
`ifndef TC_CORE_CFG_SVH
`define TC_CORE_CFG_SVH
`define CH_STRIDE_SHIFT 6
`define CH_COUNT        3
`define OFF_CTRL        6'h00
`define OFF_MODE        6'h04
`define OFF_VALUE       6'h10
`define OFF_CAPB        6'h18
`define OFF_CMPC        6'h1C
`define OFF_STATUS      6'h20
`define OFF_IMASK       6'h24
`define OFF_BLK_CTRL    8'hC0
`define OFF_BLK_MODE    8'hC4
`define CTRL_CLOCK_ENABLE_COMMAND      0
`define CTRL_CLOCK_DISABLE_COMMAND     1
`define CTRL_SOFTWARE_TRIGGER_BIT      2
`define BCTRL_SYNC      0
`define MODE_CLKSEL_LSB 0
`define MODE_CLOCK_INVERT_BIT       3
`define MODE_BURST_LSB  4
`define MODE_STOP_ON_B_LOAD    6
`define MODE_DISABLE_ON_B_LOAD     7
`define MODE_ETRGEDG_LSB 8
`define MODE_ABETRG     10
`define MODE_EEVTEDG_LSB 11
`define MODE_EEVT_LSB   13
`define MODE_RC_COMPARE_TRIGGER_ENABLE     15
`define MODE_ENETRG     16
`define MODE_WAVE       17
`define MODE_STOP_ON_RC_COMPARE    18
`define MODE_DISABLE_ON_RC_COMPARE     19
`define MODE_WIDTH      20
`define ST_OVF          0
`define ST_CPC          4
`define ST_LDB          6
`define ST_ETRG         7
`define ST_CLOCK_ENABLED_STATUS       16
`define ST_IOA          17
`define ST_IOB          18
`define ST_STICKY_W     8
`define MODE_RESET      20'h00000
`define CMPC_RESET      16'h0000
`define BMODE_RESET     6'h00
`define CV_MAX          16'hFFFF
`define CV_ZERO         16'h0000
`endif

// *** src/tc_core_pkg.sv ***
// Types shared by the timer core.
package tc_core_pkg;
    typedef logic [15:0] count_t;
    typedef logic [7:0]  apb_addr_t;
    typedef logic [31:0] apb_data_t;
    typedef logic [2:0]  chan_vec_t;
    typedef logic [1:0]  edge_sel_t;
endpackage

// *** sim/tc_core_monitor.sv ***
// Concurrent checks on the ports of the timer core.
`timescale 1ns/100ps
`default_nettype none
module tc_core_monitor
(
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire tc_core_pkg::apb_data_t prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire tc_core_pkg::chan_vec_t io_line_a_out,
    input wire tc_core_pkg::chan_vec_t io_line_a_oe,
    input wire tc_core_pkg::chan_vec_t io_line_b_out,
    input wire tc_core_pkg::chan_vec_t io_line_b_oe
);
    import tc_core_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    a_ready_after_setup: assert property (setup_s |=> access_s)
        else $error("no answer one cycle after setup");
    a_ready_one_cycle: assert property (access_s |=> !pready)
        else $error("pready held past the access");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside an access");
    a_err_reads_zero: assert property
        (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer not clean");
    a_write_no_data: assert property
        (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    a_idle_no_ready: assert property (!psel |=> !pready)
        else $error("pready without a setup");
    a_b_drive_wave: assert property
        ((io_line_b_oe & ~io_line_a_oe) == 3'h0)
        else $error("io b driven outside waveform mode");
    a_a_out_capture: assert property
        ((io_line_a_out & ~io_line_a_oe) == 3'h0)
        else $error("io a output set while not driven");
    a_b_out_low: assert property (io_line_b_out == 3'h0)
        else $error("io b output not low");
endmodule
bind three_channel_timer_counter_core tc_core_monitor tc_core_monitor_inst
(
    .clk          (clk),
    .reset        (reset),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .io_line_a_out(io_line_a_out),
    .io_line_a_oe (io_line_a_oe),
    .io_line_b_out(io_line_b_out),
    .io_line_b_oe (io_line_b_oe)
);
`default_nettype wire

// *** sim/tc_ext_model.sv ***
// Model of the external clock pins and the io line wires.
`timescale 1ns/100ps
`default_nettype none
module tc_ext_model
(
    input  wire logic                   clk,
    output var  tc_core_pkg::chan_vec_t external_clock_pins,
    output var  tc_core_pkg::chan_vec_t io_line_a_in,
    output var  tc_core_pkg::chan_vec_t io_line_b_in,
    input  wire tc_core_pkg::chan_vec_t io_line_a_out,
    input  wire tc_core_pkg::chan_vec_t io_line_a_oe,
    input  wire tc_core_pkg::chan_vec_t io_line_b_out,
    input  wire tc_core_pkg::chan_vec_t io_line_b_oe
);
    import tc_core_pkg::*;
    chan_vec_t pin_drv = 3'h0;
    chan_vec_t a_drv = 3'h0;
    // Lines nobody drives are pulled low, as a board pull-down would.
    always_comb external_clock_pins = pin_drv;
    always_comb io_line_a_in = (io_line_a_oe & io_line_a_out)
                               | (~io_line_a_oe & a_drv);
    always_comb io_line_b_in = io_line_b_oe & io_line_b_out;
    // Each level stands four master cycles, so a period spans eight.
    task automatic level(input int src, input logic v);
        @(posedge clk);
        if (src < 3)
            pin_drv[src] <= v;
        else
            a_drv[src-3] <= v;
        repeat (3) @(posedge clk);
    endtask
    task automatic pulses(input int src, input int n);
        repeat (n)
        begin
            level(src, 1'b1);
            level(src, 1'b0);
        end
    endtask
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench for the three-channel timer core.
`timescale 1ns/100ps
`default_nettype none
`include "tc_core_cfg.svh"
module testbench;
    import tc_core_pkg::*;
    logic        clk;
    logic        reset;
    apb_addr_t   paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    apb_data_t   pwdata;
    apb_data_t   prdata;
    logic        pready;
    logic        pslverr;
    chan_vec_t   pins;
    chan_vec_t   a_in;
    chan_vec_t   a_out;
    chan_vec_t   a_oe;
    chan_vec_t   b_in;
    chan_vec_t   b_out;
    chan_vec_t   b_oe;
    chan_vec_t   irq;
    int          errors;
    int          checks_done;
    logic [32:0] exp_q[$];
    apb_data_t   v;
    int          dv[5] = '{2, 8, 32, 128, 1024};
    three_channel_timer_counter_core three_channel_timer_counter_core_inst
    (
        .clk                (clk),
        .reset              (reset),
        .paddr              (paddr),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .pwdata             (pwdata),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .external_clock_pins(pins),
        .io_line_a_in       (a_in),
        .io_line_a_out      (a_out),
        .io_line_a_oe       (a_oe),
        .io_line_b_in       (b_in),
        .io_line_b_out      (b_out),
        .io_line_b_oe       (b_oe),
        .chan_irq           (irq)
    );
    tc_ext_model ext
    (
        .clk                (clk),
        .external_clock_pins(pins),
        .io_line_a_in       (a_in),
        .io_line_b_in       (b_in),
        .io_line_a_out      (a_out),
        .io_line_a_oe       (a_oe),
        .io_line_b_out      (b_out),
        .io_line_b_oe       (b_oe)
    );
    always #4 clk = ~clk;
    task automatic complete_run();
        if (errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // A transfer ends one edge after the release, so psel is never set twice.
    task automatic apb(input apb_addr_t a, input logic w, input apb_data_t d,
                       output apb_data_t r);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    function automatic apb_addr_t ad(input logic [1:0] c, input logic [5:0] o);
        return {c, o};
    endfunction
    task automatic wr(input apb_addr_t a, input apb_data_t d);
        apb_data_t r;
        apb(a, 1'b1, d, r);
    endtask
    task automatic rd(input apb_addr_t a, input logic [32:0] e);
        apb_data_t r;
        exp_q.push_back(e);
        apb(a, 1'b0, 32'h0, r);
    endtask
    task automatic rv(input logic [1:0] c, input logic [32:0] e);
        rd(ad(c, `OFF_VALUE), e);
    endtask
    task automatic oe_case(input apb_data_t m, input logic [5:0] e);
        wr(ad(2'h2, `OFF_MODE), m);
        repeat (2) @(posedge clk);
        check({27'h0, a_oe, b_oe}, {27'h0, e});
    endtask
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
            check({pslverr, prdata}, exp_q.pop_front());
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        complete_run();
    end
    initial
    begin
        clk = 1'b0;
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        checks_done = 0;
        v = $urandom(16151);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rd(ad(2'h0, `OFF_MODE), 33'h0);
        rd(ad(2'h0, `OFF_STATUS), 33'h0);
        rv(2'h1, 33'h0);
        rd(8'h30, 33'h100000000);
        v = 32'h8000 | ($urandom & 32'h7FFF);
        wr(ad(2'h0, `OFF_CMPC), v);
        rd(ad(2'h0, `OFF_CMPC), {1'b0, v});
        wr(ad(2'h0, `OFF_CTRL), 32'h5);
        for (int s = 0; s < 5; s++)
        begin
            wr(ad(2'h0, `OFF_MODE), 32'(s));
            apb(ad(2'h0, `OFF_VALUE), 1'b0, 32'h0, v);
            repeat (dv[s] * 4 - 3) @(posedge clk);
            rv(2'h0, {17'h0, v[15:0] + 16'h4});
        end
        wr(ad(2'h0, `OFF_MODE), 32'h5);
        wr(ad(2'h0, `OFF_CTRL), 32'h4);
        ext.pulses(0, 5);
        rv(2'h0, 33'h4);
        wr(ad(2'h0, `OFF_CTRL), 32'h4);
        rv(2'h0, 33'h4);
        ext.pulses(0, 1);
        rv(2'h0, 33'h0);
        ext.level(0, 1'b1);
        wr(ad(2'h0, `OFF_MODE), 32'hD);
        rv(2'h0, 33'h1);
        ext.level(0, 1'b0);
        rv(2'h0, 33'h2);
        ext.pulses(0, 1);
        rv(2'h0, 33'h3);
        wr(ad(2'h0, `OFF_MODE), 32'h25);
        ext.pulses(0, 2);
        rv(2'h0, 33'h3);
        ext.level(1, 1'b1);
        ext.pulses(0, 2);
        rv(2'h0, 33'h5);
        ext.level(1, 1'b0);
        wr(ad(2'h0, `OFF_MODE), 32'h5);
        wr(ad(2'h0, `OFF_CTRL), 32'h2);
        rd(ad(2'h0, `OFF_STATUS), 33'h0);
        wr(ad(2'h0, `OFF_CTRL), 32'h4);
        ext.pulses(0, 2);
        rv(2'h0, 33'h5);
        wr(ad(2'h0, `OFF_CTRL), 32'h1);
        rd(ad(2'h0, `OFF_STATUS), 33'h10000);
        ext.pulses(0, 2);
        rv(2'h0, 33'h5);
        wr(ad(2'h0, `OFF_CTRL), 32'h3);
        rd(ad(2'h0, `OFF_STATUS), 33'h0);
        wr(ad(2'h0, `OFF_CMPC), 32'h3);
        wr(ad(2'h0, `OFF_IMASK), 32'h10);
        wr(ad(2'h0, `OFF_MODE), 32'h8005);
        wr(ad(2'h0, `OFF_CTRL), 32'h5);
        ext.pulses(0, 6);
        rv(2'h0, 33'h1);
        check({32'h0, irq[0]}, 33'h1);
        rd(ad(2'h0, `OFF_STATUS), 33'h10010);
        repeat (2) @(posedge clk);
        check({32'h0, irq[0]}, 33'h0);
        wr(ad(2'h1, `OFF_MODE), 32'h5);
        wr(ad(2'h2, `OFF_MODE), 32'h5);
        wr(ad(2'h1, `OFF_CTRL), 32'h1);
        wr(ad(2'h2, `OFF_CTRL), 32'h1);
        ext.pulses(0, 1);
        rv(2'h2, 33'h0);
        wr(`OFF_BLK_CTRL, 32'h1);
        ext.pulses(0, 3);
        rv(2'h1, 33'h2);
        rv(2'h2, 33'h2);
        wr(`OFF_BLK_MODE, 32'h2);
        rd(`OFF_BLK_MODE, 33'h2);
        wr(ad(2'h0, `OFF_MODE), 32'h5);
        wr(ad(2'h0, `OFF_CTRL), 32'h4);
        ext.pulses(4, 3);
        rv(2'h0, 33'h2);
        oe_case(32'h20000, 6'h20);
        oe_case(32'h22000, 6'h24);
        oe_case(32'h0, 6'h0);
        check(33'(exp_q.size()), 33'h0);
        complete_run();
    end
endmodule
`default_nettype wire
